// File: bench/ccsr_chk.sv
// Port assertions for the special-function register set
// Bound to ccsr_regs; one clock, srst synchronous active high
`timescale 1ns/1ps
module ccsr_chk (
    input wire clk, input wire srst, input wire [7:0] sfr_addr, input wire sfr_wr,
    input wire [7:0] sfr_wdata, input wire stack_push, input wire alu_cy_we,
    input wire alu_cy, input wire [7:0] primary_operand_r, input wire [7:0] status_flags_r,
    input wire [7:0] stack_pointer_r, input wire [7:0] stack_write_addr_r,
    input wire [4:0] bank_base_r, input wire [15:0] ext_address_pointer_r,
    input wire [15:0] code_index_addr_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_push_only;
        stack_push && !(sfr_wr && sfr_addr == 8'h81);
    endsequence
    a_sp_reset_val: assert property ($past(srst) |-> stack_pointer_r == 8'h07)
        else $error("sp not 07");
    a_push_pre_inc: assert property (s_push_only |=> stack_pointer_r == $past(stack_pointer_r) + 8'h01)
        else $error("push step");
    a_push_addr: assert property (stack_write_addr_r == stack_pointer_r + 8'h01)
        else $error("push address");
    a_bank_base: assert property (bank_base_r == {status_flags_r[4:3], 3'b000})
        else $error("bank base");
    a_parity_view: assert property (status_flags_r[0] == ^primary_operand_r)
        else $error("parity");
    a_index_sum: assert property (code_index_addr_r == ext_address_pointer_r + {8'h00, primary_operand_r})
        else $error("index sum");
    a_bus_wins: assert property (sfr_wr && sfr_addr == 8'hE0 |=> primary_operand_r == $past(sfr_wdata))
        else $error("bus write lost");
    a_carry_upd: assert property (alu_cy_we && !(sfr_wr && sfr_addr == 8'hD0) |=> status_flags_r[7] == $past(alu_cy))
        else $error("carry update");
endmodule
bind ccsr_regs ccsr_chk i_chk (.clk(clk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .stack_push(stack_push), .alu_cy_we(alu_cy_we), .alu_cy(alu_cy),
    .primary_operand_r(primary_operand_r), .status_flags_r(status_flags_r),
    .stack_pointer_r(stack_pointer_r), .stack_write_addr_r(stack_write_addr_r),
    .bank_base_r(bank_base_r), .ext_address_pointer_r(ext_address_pointer_r),
    .code_index_addr_r(code_index_addr_r));

// File: bench/ccsr_icu_model.sv
// Instruction unit stand-in: decodes a one-cycle op into update strobes
// Op and argument change just after a rising edge, held one cycle
`timescale 1ns/1ps
module ccsr_icu_model (
    input wire [2:0] op,
    output wire por_we, output wire sor_we, output wire flg_we, output wire push,
    output wire pop, output wire ld16, output wire inc
);
    assign por_we = op == 3'h1;
    assign flg_we = op == 3'h1;
    assign sor_we = op == 3'h6;
    assign push = op == 3'h2;
    assign pop = op == 3'h3;
    assign ld16 = op == 3'h4;
    assign inc = op == 3'h5;
endmodule

// File: bench/cpu_core_special_registers_tb_top.sv
// Self-checking bench for ccsr_regs with the instruction unit stand-in
// Bus and op codes change at rising edges by non-blocking assignment
`timescale 1ns/1ps
module cpu_core_special_registers_tb_top;
    reg clk = 0, srst = 1, wr = 0, rd = 0;
    reg [7:0] addr = 8'h00, wd = 8'h00;
    reg [2:0] op = 3'h0;
    reg [15:0] arg = 16'h0000;
    integer n_errors = 0, cmp_count = 0, i;
    wire [7:0] rdat, por, sor, psf, sp, swa;
    wire [4:0] bank;
    wire [15:0] ptr, cidx;
    wire hit, pwe, swe, fwe, psh, pop, ld, inc;
    ccsr_icu_model i_icu (.op(op), .por_we(pwe), .sor_we(swe), .flg_we(fwe),
        .push(psh), .pop(pop), .ld16(ld), .inc(inc));
    ccsr_regs i_dut (.clk(clk), .srst(srst), .sfr_addr(addr), .sfr_wr(wr), .sfr_wdata(wd),
        .sfr_rd(rd), .sfr_rdata_r(rdat), .sfr_hit_r(hit), .alu_por_we(pwe),
        .alu_por_data(arg[7:0]), .alu_sor_we(swe), .alu_sor_data(arg[7:0]),
        .alu_cy_we(fwe), .alu_cy(arg[8]), .alu_hc_we(fwe), .alu_hc(arg[9]),
        .alu_ov_we(fwe), .alu_ov(arg[10]), .stack_push(psh), .stack_pop(pop),
        .ptr_load16(ld), .ptr_data16(arg), .ptr_inc(inc), .primary_operand_r(por),
        .second_operand_r(sor), .status_flags_r(psf), .stack_pointer_r(sp),
        .stack_write_addr_r(swa), .bank_base_r(bank), .ext_address_pointer_r(ptr),
        .code_index_addr_r(cidx));
    initial forever #20 clk = ~clk;
    task chk(input [15:0] got, input [15:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One request cycle; outputs settle 1 ns after the taking edge
    task cyc(input w, input r, input [7:0] a, input [7:0] d, input [2:0] o, input [15:0] g);
        @(posedge clk);
        wr <= w;
        rd <= r;
        addr <= a;
        wd <= d;
        op <= o;
        arg <= g;
        @(posedge clk);
        wr <= 0;
        rd <= 0;
        op <= 0;
        #1;
    endtask
    task rdc(input [7:0] a, input [7:0] e, input h);
        cyc(0, 1, a, 0, 0, 0);
        chk(rdat, e);
        chk(hit, h);
    endtask
    task t_reset;
        rdc(8'hE0, 8'h00, 1);
        rdc(8'hF0, 8'h00, 1);
        rdc(8'hD0, 8'h00, 1);
        rdc(8'h81, 8'h07, 1);
        rdc(8'h82, 8'h00, 1);
        rdc(8'h83, 8'h00, 1);
        rdc(8'h85, 8'h00, 0);
        chk(swa, 8'h08);
        $display("test reset done");
    endtask
    task t_regs;
        cyc(1, 0, 8'hE0, 8'h03, 0, 0);
        chk(psf[0], 0);
        cyc(1, 0, 8'hF0, 8'hA5, 0, 0);
        cyc(1, 0, 8'h82, 8'h34, 0, 0);
        cyc(1, 0, 8'h83, 8'h12, 0, 0);
        cyc(1, 0, 8'hD0, 8'hFF, 0, 0);
        rdc(8'hD0, 8'hFE, 1);
        rdc(8'hF0, 8'hA5, 1);
        chk(ptr, 16'h1234);
        chk(cidx, 16'h1237);
        for (i = 0; i < 4; i = i + 1) begin
            cyc(1, 0, 8'hD0, i << 3, 0, 0);
            chk(bank, i * 8);
        end
        cyc(1, 0, 8'hE0, 8'h07, 0, 0);
        chk(psf[0], 1);
        rdc(8'hD0, 8'h19, 1);
        $display("test registers done");
    endtask
    task t_stack;
        cyc(1, 0, 8'h81, 8'h07, 0, 0);
        cyc(0, 0, 0, 0, 3'h2, 0);
        chk(sp, 8'h08);
        chk(swa, 8'h09);
        cyc(0, 0, 0, 0, 3'h2, 0);
        cyc(0, 0, 0, 0, 3'h3, 0);
        chk(sp, 8'h08);
        cyc(1, 0, 8'h81, 8'h40, 3'h2, 0);
        rdc(8'h81, 8'h40, 1);
        $display("test stack done");
    endtask
    task t_alu;
        cyc(0, 0, 0, 0, 3'h1, 16'h0701);
        chk(por, 8'h01);
        chk(psf, 8'hDD);
        cyc(1, 0, 8'hD0, 8'h00, 3'h1, 16'h0703);
        chk(psf, 8'h00);
        cyc(0, 0, 0, 0, 3'h6, 16'h005A);
        chk(sor, 8'h5A);
        cyc(0, 0, 0, 0, 3'h4, 16'hABCD);
        cyc(0, 0, 0, 0, 3'h5, 0);
        chk(ptr, 16'hABCE);
        chk(cidx, 16'hABD1);
        rdc(8'h83, 8'hAB, 1);
        $display("test alu done");
    endtask
    task t_midrst;
        cyc(1, 0, 8'h81, 8'h55, 0, 0);
        cyc(1, 0, 8'hD0, 8'hFF, 0, 0);
        @(posedge clk);
        srst <= 1;
        @(posedge clk);
        srst <= 0;
        #1;
        chk(por, 8'h00);
        chk(psf, 8'h00);
        chk(sp, 8'h07);
        chk(swa, 8'h08);
        chk(ptr, 16'h0000);
        rdc(8'h81, 8'h07, 1);
        $display("test mid-run reset done");
    endtask
    task give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        srst <= 0;
        t_reset;
        t_regs;
        t_stack;
        t_alu;
        t_midrst;
        give_verdict;
    end
    // About 75 short cycles expected; generous margin
    initial begin
        #100000;
        n_errors = n_errors + 1;
        give_verdict;
    end
endmodule

// File: design/ccsr_consts.vh
// Constants for the core special-function register set
// Included by the register file and its parity helper
`ifndef CCSR_CONSTS_VH
`define CCSR_CONSTS_VH

// Direct addresses on the special-function bus
`define CCSR_ADDR_SP 8'h81
`define CCSR_ADDR_PLO 8'h82
`define CCSR_ADDR_PHI 8'h83
`define CCSR_ADDR_PSF 8'hD0
`define CCSR_ADDR_POR 8'hE0
`define CCSR_ADDR_SOR 8'hF0

// Reset values
`define CCSR_RST_SP 8'h07
`define CCSR_RST_BYTE 8'h00
`define CCSR_RST_BANK 2'h0
`define CCSR_RST_WORD 16'h0000

// Status flag bit positions
`define CCSR_BIT_CY 7
`define CCSR_BIT_HC 6
`define CCSR_BIT_UF0 5
`define CCSR_BIT_BANK_HI 4
`define CCSR_BIT_BANK_LO 3
`define CCSR_BIT_OV 2
`define CCSR_BIT_UF1 1
`define CCSR_BIT_PAR 0

// Working bank geometry: eight registers per bank
`define CCSR_BANK_SHIFT 3

`endif

// File: design/ccsr_parity.v
// Registered parity of the primary operand register
// Assumes the same clock and synchronous reset as the register file
`timescale 1ns/1ps
`include "ccsr_consts.vh"

module ccsr_parity #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input wire clk,
    input wire srst,
    // Value to check
    input wire [WIDTH-1:0] data,
    // Odd count of ones
    output reg odd_r
);

    always @(posedge clk) begin
        if (srst) begin
            odd_r <= 1'b0;
        end else begin
            odd_r <= ^data;
        end
    end

endmodule

// File: design/ccsr_regs.v
// Core special-function registers: operand registers, status flags,
// stack pointer and external address pointer.
// Assumes the instruction control unit and ALU drive the hardware
// update ports on clk, and the SFR bus is a single-cycle direct port.
`timescale 1ns/1ps
`include "ccsr_consts.vh"

module ccsr_regs (
    // Clock and reset
    input wire clk,
    input wire srst,
    // Special-function direct bus
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire [7:0] sfr_wdata,
    input wire sfr_rd,
    output reg [7:0] sfr_rdata_r,
    output reg sfr_hit_r,
    // ALU result writeback
    input wire alu_por_we,
    input wire [7:0] alu_por_data,
    input wire alu_sor_we,
    input wire [7:0] alu_sor_data,
    // ALU flag updates
    input wire alu_cy_we,
    input wire alu_cy,
    input wire alu_hc_we,
    input wire alu_hc,
    input wire alu_ov_we,
    input wire alu_ov,
    // Stack control
    input wire stack_push,
    input wire stack_pop,
    // Address pointer control
    input wire ptr_load16,
    input wire [15:0] ptr_data16,
    input wire ptr_inc,
    // Register views for the core
    output reg [7:0] primary_operand_r,
    output reg [7:0] second_operand_r,
    output reg [7:0] status_flags_r,
    output reg [7:0] stack_pointer_r,
    output reg [7:0] stack_write_addr_r,
    output reg [4:0] bank_base_r,
    output reg [15:0] ext_address_pointer_r,
    output reg [15:0] code_index_addr_r
);

    reg [7:0] por_r;
    reg [7:0] por_nxt;
    reg [7:0] sor_r;
    reg [7:0] sor_nxt;
    reg [7:0] sp_r;
    reg [7:0] sp_nxt;
    reg [7:0] plo_r;
    reg [7:0] plo_nxt;
    reg [7:0] phi_r;
    reg [7:0] phi_nxt;
    reg cy_r;
    reg cy_nxt;
    reg hc_r;
    reg hc_nxt;
    reg ov_r;
    reg ov_nxt;
    reg uf0_r;
    reg uf0_nxt;
    reg uf1_r;
    reg uf1_nxt;
    reg [1:0] bank_r;
    reg [1:0] bank_nxt;
    reg [15:0] ptr_sum;
    reg [7:0] rd_mux;
    reg rd_hit;
    wire par_odd;
    wire [7:0] psf_view;
    // Write select slot per mapped register
    localparam SEL_POR = 0;
    localparam SEL_SOR = 1;
    localparam SEL_SP = 2;
    localparam SEL_PLO = 3;
    localparam SEL_PHI = 4;
    localparam SEL_PSF = 5;
    localparam N_SEL = 6;
    wire [N_SEL-1:0] wr_sel;
    genvar g;

    function wr_at;
        input [7:0] addr;
        input [7:0] target;
        input wr;
        begin
            wr_at = wr && (addr == target);
        end
    endfunction

    // Bus address of each write-select slot
    function [7:0] addr_of;
        input integer idx;
        begin
            case (idx)
                SEL_POR: addr_of = `CCSR_ADDR_POR;
                SEL_SOR: addr_of = `CCSR_ADDR_SOR;
                SEL_SP: addr_of = `CCSR_ADDR_SP;
                SEL_PLO: addr_of = `CCSR_ADDR_PLO;
                SEL_PHI: addr_of = `CCSR_ADDR_PHI;
                default: addr_of = `CCSR_ADDR_PSF;
            endcase
        end
    endfunction

    // Bank base is the bank number times the bank size
    function [4:0] bank_base_of;
        input [1:0] bank;
        begin
            bank_base_of = {bank, {`CCSR_BANK_SHIFT{1'b0}}};
        end
    endfunction

    // One address comparator per mapped register
    generate
        for (g = 0; g < N_SEL; g = g + 1) begin : g_wsel
            assign wr_sel[g] = wr_at(sfr_addr, addr_of(g), sfr_wr);
        end
    endgenerate

    // Parity registered from the next operand, so it steps with the operand
    ccsr_parity #(
        .WIDTH(8)
    ) u_parity (
        .clk(clk),
        .srst(srst),
        .data(por_nxt),
        .odd_r(par_odd)
    );

    assign psf_view = {cy_r, hc_r, uf0_r, bank_r, ov_r, uf1_r, par_odd};

    // Next-state: hardware update first, bus write last so it wins
    always @* begin
        por_nxt = por_r;
        sor_nxt = sor_r;
        sp_nxt = sp_r;
        plo_nxt = plo_r;
        phi_nxt = phi_r;
        cy_nxt = cy_r;
        hc_nxt = hc_r;
        ov_nxt = ov_r;
        uf0_nxt = uf0_r;
        uf1_nxt = uf1_r;
        bank_nxt = bank_r;
        ptr_sum = {phi_r, plo_r} + 16'h0001;
        if (alu_por_we) begin
            por_nxt = alu_por_data;
        end
        if (alu_sor_we) begin
            sor_nxt = alu_sor_data;
        end
        if (alu_cy_we) begin
            cy_nxt = alu_cy;
        end
        if (alu_hc_we) begin
            hc_nxt = alu_hc;
        end
        if (alu_ov_we) begin
            ov_nxt = alu_ov;
        end
        // Eight-bit wrap; software keeps the stack inside scratchpad RAM
        if (stack_push) begin
            sp_nxt = sp_r + 8'h01;
        end else if (stack_pop) begin
            sp_nxt = sp_r - 8'h01;
        end
        // Word load beats increment so a table setup is not lost to an increment; a bus write to 82h or 83h still wins
        if (ptr_load16) begin
            {phi_nxt, plo_nxt} = ptr_data16;
        end else if (ptr_inc) begin
            {phi_nxt, plo_nxt} = ptr_sum;
        end
        if (wr_sel[SEL_POR]) begin
            por_nxt = sfr_wdata;
        end
        if (wr_sel[SEL_SOR]) begin
            sor_nxt = sfr_wdata;
        end
        if (wr_sel[SEL_SP]) begin
            sp_nxt = sfr_wdata;
        end
        if (wr_sel[SEL_PLO]) begin
            plo_nxt = sfr_wdata;
        end
        if (wr_sel[SEL_PHI]) begin
            phi_nxt = sfr_wdata;
        end
        // Parity bit is hardware-owned; a write to it is dropped
        if (wr_sel[SEL_PSF]) begin
            cy_nxt = sfr_wdata[`CCSR_BIT_CY];
            hc_nxt = sfr_wdata[`CCSR_BIT_HC];
            ov_nxt = sfr_wdata[`CCSR_BIT_OV];
            uf0_nxt = sfr_wdata[`CCSR_BIT_UF0];
            uf1_nxt = sfr_wdata[`CCSR_BIT_UF1];
            bank_nxt = sfr_wdata[`CCSR_BIT_BANK_HI:`CCSR_BIT_BANK_LO];
        end
    end

    // Read decode
    always @* begin
        rd_hit = 1'b1;
        case (sfr_addr)
            `CCSR_ADDR_POR: rd_mux = por_r;
            `CCSR_ADDR_SOR: rd_mux = sor_r;
            `CCSR_ADDR_SP: rd_mux = sp_r;
            `CCSR_ADDR_PLO: rd_mux = plo_r;
            `CCSR_ADDR_PHI: rd_mux = phi_r;
            `CCSR_ADDR_PSF: rd_mux = psf_view;
            default: begin
                rd_mux = `CCSR_RST_BYTE;
                rd_hit = 1'b0;
            end
        endcase
    end

    always @(posedge clk) begin
        if (srst) begin
            por_r <= `CCSR_RST_BYTE;
            sor_r <= `CCSR_RST_BYTE;
            sp_r <= `CCSR_RST_SP;
            plo_r <= `CCSR_RST_BYTE;
            phi_r <= `CCSR_RST_BYTE;
            cy_r <= 1'b0;
            hc_r <= 1'b0;
            ov_r <= 1'b0;
            uf0_r <= 1'b0;
            uf1_r <= 1'b0;
            bank_r <= `CCSR_RST_BANK;
        end else begin
            por_r <= por_nxt;
            sor_r <= sor_nxt;
            sp_r <= sp_nxt;
            plo_r <= plo_nxt;
            phi_r <= phi_nxt;
            cy_r <= cy_nxt;
            hc_r <= hc_nxt;
            ov_r <= ov_nxt;
            uf0_r <= uf0_nxt;
            uf1_r <= uf1_nxt;
            bank_r <= bank_nxt;
        end
    end

    // Read data idles at zero so several blocks can share an OR-ed return
    always @(posedge clk) begin
        if (srst) begin
            sfr_rdata_r <= `CCSR_RST_BYTE;
            sfr_hit_r <= 1'b0;
        end else begin
            sfr_rdata_r <= sfr_rd ? rd_mux : `CCSR_RST_BYTE;
            sfr_hit_r <= sfr_rd & rd_hit;
        end
    end

    // Views mirror the next state so they match the stored registers
    always @(posedge clk) begin
        if (srst) begin
            primary_operand_r <= `CCSR_RST_BYTE;
            second_operand_r <= `CCSR_RST_BYTE;
            status_flags_r <= `CCSR_RST_BYTE;
            stack_pointer_r <= `CCSR_RST_SP;
            stack_write_addr_r <= `CCSR_RST_SP + 8'h01;
            bank_base_r <= bank_base_of(`CCSR_RST_BANK);
            ext_address_pointer_r <= `CCSR_RST_WORD;
            code_index_addr_r <= `CCSR_RST_WORD;
        end else begin
            primary_operand_r <= por_nxt;
            second_operand_r <= sor_nxt;
            status_flags_r <= {cy_nxt, hc_nxt, uf0_nxt, bank_nxt, ov_nxt, uf1_nxt,
                ^por_nxt};
            stack_pointer_r <= sp_nxt;
            stack_write_addr_r <= sp_nxt + 8'h01;
            bank_base_r <= bank_base_of(bank_nxt);
            ext_address_pointer_r <= {phi_nxt, plo_nxt};
            code_index_addr_r <= {phi_nxt, plo_nxt} + {8'h00, por_nxt};
        end
    end

endmodule
